// [core/ipg_pkg.sv]
// What this block does
// [RULE1] Repurpose bit 2 set: pin becomes general output at active-level bit value.
// [RULE2] Idle high-impedance bit 1 set: pin driven only while asserted, else floats.
// [RULE3] Active-level bit 0: 0 drives low for interrupt, 1 drives high.
// [RULE4] Key in a protected range: only writes to the key register are accepted.
// [RULE5] Key equal to fully-unprotected value: every writeable register accepts writes.
// [RULE6] Key equal to single-unprotected value: one other write accepted, then protected.
// [RULE7] Pin configuration bits 7 to 3 ignore writes and read as zero.
package ipg_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] ADDR_IRQ_PIN_CONFIG = 8'h7d;
   localparam logic [7:0] ADDR_WRITE_GUARD_KEY = 8'h7e;
   localparam logic [7:0] RST_IRQ_PIN_CONFIG = 8'h02;
   localparam logic [7:0] RST_WRITE_GUARD_KEY = 8'h85;
   localparam logic [7:0] KEY_FULL_OPEN = 8'h85;
   localparam logic [7:0] KEY_SINGLE_OPEN = 8'h86;
   localparam logic [7:0] KEY_RELOCK = 8'h00;
   localparam logic [7:0] CFG_USED_MASK = 8'h07;
   localparam int BIT_POLARITY = 0;
   localparam int BIT_TRISTATE = 1;
   localparam int BIT_REPURPOSE = 2;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic pinRepurposeEn;
      logic tristateEn;
      logic intPolarity;
   } ipg_cfg_t;

   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } ipg_req_t;
endpackage

// [core/ipg_pin_drive.sv]
`timescale 1ns/100ps
module ipg_pin_drive
   import ipg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire ipg_cfg_t cfg,
   input wire logic irqActive,
   // Pin
   output logic pinOut,
   output logic pinOeN
);
   logic next_pinOut;
   logic next_pinOeN;

   always_comb begin
      next_pinOut = cfg.intPolarity;
      next_pinOeN = 1'b0;
      if (cfg.pinRepurposeEn) begin
         // [RULE1] General output level
         next_pinOut = cfg.intPolarity;
         next_pinOeN = 1'b0;
      end else begin
         // [RULE3] Polarity of assertion
         next_pinOut = irqActive ? cfg.intPolarity : ~cfg.intPolarity;
         // [RULE2] Float when idle
         next_pinOeN = cfg.tristateEn & ~irqActive;
      end
   end

   // Registered so the pin never glitches on config writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinOut <= 1'b1;
         pinOeN <= 1'b1;
      end else begin
         pinOut <= next_pinOut;
         pinOeN <= next_pinOeN;
      end
   end
endmodule

// [core/ipg_guard.sv]
`timescale 1ns/100ps
module ipg_guard
   import ipg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire ipg_req_t req,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic wrRejected,
   // Other registers behind the guard
   output logic extWrEn,
   output logic [7:0] extAddr,
   output logic [7:0] extWrData,
   // Interrupt source and pin
   input wire logic irqActive,
   output logic irqPinOut,
   output logic irqPinOeN
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] pinCfg;
   logic [7:0] guardKey;
   logic [7:0] next_guardKey;
   logic [7:0] next_pinCfg;
   logic [7:0] next_rdData;
   logic keyHit;
   logic cfgHit;
   logic otherWr;
   logic wrAllowed;
   logic keyOpen;
   logic singleOpen;
   ipg_cfg_t cfg;

   // ****************************************
   // Helper functions
   // ****************************************
   // Both unlock values open the gate; every other value is protected
   function automatic logic keyAllows(input logic [7:0] key);
      keyAllows = (key == KEY_FULL_OPEN) || (key == KEY_SINGLE_OPEN);
   endfunction

   function automatic logic isCfgAddr(input logic [7:0] addr);
      isCfgAddr = addr == ADDR_IRQ_PIN_CONFIG;
   endfunction

   function automatic logic isKeyAddr(input logic [7:0] addr);
      isKeyAddr = addr == ADDR_WRITE_GUARD_KEY;
   endfunction

   // ****************************************
   // Address decode
   // ****************************************
   assign keyHit = isKeyAddr(req.addr);
   assign cfgHit = isCfgAddr(req.addr);
   assign otherWr = req.wrEn && !keyHit;
   assign keyOpen = keyAllows(guardKey);
   assign singleOpen = guardKey == KEY_SINGLE_OPEN;
   // [RULE4] Protected ranges block others
   assign wrAllowed = otherWr && keyOpen;

   // ****************************************
   // Write guard key
   // ****************************************
   always_comb begin
      next_guardKey = guardKey;
      if (req.wrEn && keyHit) begin
         // [RULE4] Key always writable
         next_guardKey = req.wrData;
      end else if (wrAllowed && singleOpen) begin
         // [RULE6] One write then relock
         next_guardKey = KEY_RELOCK;
      end
   end

   // Key write wins over relock so a fresh unlock is never lost
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         guardKey <= RST_WRITE_GUARD_KEY;
      end else begin
         guardKey <= next_guardKey;
      end
   end

   // ****************************************
   // Pin configuration
   // ****************************************
   always_comb begin
      next_pinCfg = pinCfg;
      if (wrAllowed && cfgHit) begin
         // [RULE7] Unused bits dropped
         next_pinCfg = req.wrData & CFG_USED_MASK;
      end
   end

   // Config write also uses up a single unlock
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pinCfg <= RST_IRQ_PIN_CONFIG;
      end else begin
         pinCfg <= next_pinCfg;
      end
   end

   // ****************************************
   // Field view
   // ****************************************
   assign cfg.pinRepurposeEn = pinCfg[BIT_REPURPOSE];
   assign cfg.tristateEn = pinCfg[BIT_TRISTATE];
   assign cfg.intPolarity = pinCfg[BIT_POLARITY];

   // ****************************************
   // Pass-on port
   // ****************************************
   // [RULE5] Open key passes writes on
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         extWrEn <= 1'b0;
      end else begin
         extWrEn <= wrAllowed && !cfgHit;
      end
   end

   // Address and data follow every cycle; only the strobe qualifies them
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         extAddr <= 8'h00;
      end else begin
         extAddr <= req.addr;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         extWrData <= 8'h00;
      end else begin
         extWrData <= req.wrData;
      end
   end

   // [RULE4] Refused write flagged
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrRejected <= 1'b0;
      end else begin
         wrRejected <= otherWr && !keyOpen;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   // Unmapped addresses read as zero
   always_comb begin
      next_rdData = 8'h00;
      if (!req.rdEn) begin
         next_rdData = 8'h00;
      end else if (cfgHit) begin
         // [RULE7] Unused bits read zero
         next_rdData = pinCfg;
      end else if (keyHit) begin
         next_rdData = guardKey;
      end else begin
         next_rdData = 8'h00;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdData <= 8'h00;
      end else begin
         rdData <= next_rdData;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdValid <= 1'b0;
      end else begin
         rdValid <= req.rdEn;
      end
   end

   // ****************************************
   // Pin driver
   // ****************************************
   // Pin lags the config register by one cycle
   ipg_pin_drive uPin (
      .mclk(mclk),
      .rst(rst),
      .cfg(cfg),
      .irqActive(irqActive),
      .pinOut(irqPinOut),
      .pinOeN(irqPinOeN)
   );
endmodule

// [sim/ipg_guard_checker.sv]
`timescale 1ns/100ps
module ipg_chk
   import ipg_pkg::*;
(
   input wire logic mclk, rst, irqActive, rdValid, wrRejected, extWrEn, irqPinOut, irqPinOeN,
   input wire ipg_req_t req,
   input wire logic [7:0] rdData, extAddr, extWrData
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_read_answer: assert property (
      req.rdEn |=> rdValid) else $error("no read answer");
   chk_cfg_zero: assert property (
      req.rdEn && req.addr == ADDR_IRQ_PIN_CONFIG |=> rdData[7:3] == 5'h00)
      else $error("unused bits set");
   chk_reject_cause: assert property (
      wrRejected |-> $past(req.wrEn && req.addr != ADDR_WRITE_GUARD_KEY))
      else $error("bad reject");
   chk_ext_copy: assert property (
      extWrEn |-> $past(req.wrEn) && extAddr == $past(req.addr) &&
      extWrData == $past(req.wrData)) else $error("bad pass");
   chk_one_verdict: assert property (
      !(extWrEn && wrRejected)) else $error("both");
   chk_active_driven: assert property (
      irqPinOeN && !$past(rst) |-> !$past(irqActive)) else $error("active pin floats");
   cover property (extWrEn);
   cover property (wrRejected);
   cover property (!irqPinOeN && irqPinOut);
endmodule
bind ipg_guard ipg_chk chk (.*);

// [sim/ipg_host.sv]
`timescale 1ns/100ps
module ipg_host
(
   input wire logic pinOut, pinOeN,
   output logic pinLvl
);
   // Pull-up holds a released shared line high
   assign pinLvl = pinOeN ? 1'b1 : pinOut;
endmodule

// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import ipg_pkg::*;
   logic mclk = 0, rst = 1, irqActive = 0, pinLvl, rdValid, wrRejected, extWrEn;
   logic irqPinOut, irqPinOeN;
   logic [7:0] rdData, extAddr, extWrData;
   ipg_req_t req = '0;
   int fails = 0, compares = 0, cyc = 0;
   ipg_guard dut (.mclk(mclk), .rst(rst), .req(req), .rdData(rdData), .rdValid(rdValid),
      .wrRejected(wrRejected), .extWrEn(extWrEn), .extAddr(extAddr), .extWrData(extWrData),
      .irqActive(irqActive), .irqPinOut(irqPinOut), .irqPinOeN(irqPinOeN));
   ipg_host host (.pinOut(irqPinOut), .pinOeN(irqPinOeN), .pinLvl(pinLvl));
   initial forever #12.5 mclk = ~mclk;
   task chk(logic [15:0] g, e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task wr(logic [7:0] a, d, logic [1:0] e);
      @(negedge mclk) req = {2'b10, a, d};
      @(negedge mclk) req = '0;
      chk({14'h0, extWrEn, wrRejected}, {14'h0, e});
      if (e[1]) chk({extAddr, extWrData}, {a, d});
   endtask
   task rd(logic [7:0] a, e);
      @(negedge mclk) req = {2'b01, a, 8'h00};
      @(negedge mclk) req = '0;
      chk({7'h00, rdValid, rdData}, {8'h01, e});
   endtask
   task pin(logic [2:0] c, logic a);
      wr(ADDR_IRQ_PIN_CONFIG, {5'h00, c}, 2'b00);
      irqActive = a;
      @(negedge mclk);
      @(negedge mclk);
      chk({14'h0, irqPinOeN, pinLvl}, {14'h0, (c[2] | a) ? {1'b0, c[0]} : {c[1], c[1] | ~c[0]}});
   endtask
   task t_pins;
      for (int i = 0; i < 16; i++) pin(i[2:0], i[3]);
      $display("pins done");
   endtask
   task t_regs;
      rd(ADDR_WRITE_GUARD_KEY, RST_WRITE_GUARD_KEY);
      wr(ADDR_IRQ_PIN_CONFIG, 8'hff, 2'b00);
      rd(ADDR_IRQ_PIN_CONFIG, 8'h07);
      $display("regs done");
   endtask
   task t_guard;
      logic [7:0] k [4] = '{8'h00, 8'h84, 8'h87, 8'hff};
      foreach (k[i]) begin
         wr(ADDR_WRITE_GUARD_KEY, k[i], 2'b00);
         wr(ADDR_IRQ_PIN_CONFIG, 8'h00, 2'b01);
      end
      rd(ADDR_IRQ_PIN_CONFIG, 8'h07);
      wr(ADDR_WRITE_GUARD_KEY, KEY_SINGLE_OPEN, 2'b00);
      wr(8'h40, 8'haa, 2'b10);
      wr(8'h41, 8'hbb, 2'b01);
      rd(ADDR_WRITE_GUARD_KEY, KEY_RELOCK);
      wr(ADDR_WRITE_GUARD_KEY, KEY_FULL_OPEN, 2'b00);
      wr(8'h40, 8'h11, 2'b10);
      wr(8'h41, 8'h22, 2'b10);
      rd(8'h40, 8'h00);
      $display("guard done");
   endtask
   task give_verdict;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard, runs need under 400 cycles
   always @(posedge mclk) if (++cyc > 2000) begin
      fails++;
      give_verdict;
   end
   initial begin
      #50 rst = 0;
      t_regs;
      t_pins;
      t_guard;
      give_verdict;
   end
endmodule
